// >>> recorder_serial_link_pkg.sv
package recorder_serial_link_pkg;

    // Clock and link timing
    localparam int CLOCK_HZ = 40_000_000;
    localparam int BAUD_RATE = 38_400;
    localparam int BAUD_DIV_INT = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam logic [10:0] BAUD_DIV = BAUD_DIV_INT[10:0];
    localparam logic [10:0] HALF_BIT = BAUD_DIV_INT[11:1];
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    // Register byte offsets
    localparam logic [5:0] OFS_TX_DATA = 6'h00;
    localparam logic [5:0] OFS_RX_DATA = 6'h04;
    localparam logic [5:0] OFS_CONTROL = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h10;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h14;

    // Event bit positions in interrupt status and mask
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_BYTE = 1;
    localparam int EV_READY = 2;
    localparam int EV_FAN_CHANGE = 3;
    localparam int EV_FRAME_ERR = 4;
    localparam int EV_WIDTH = 5;

    // Status bit positions
    localparam int ST_TX_BUSY = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_CTS = 2;
    localparam int ST_READY = 3;
    localparam int ST_FAN_RUNNING = 4;
    localparam int ST_RX_VALID = 5;
    localparam int RX_VALID_BIT = 8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register layout, bit 2 downward
    typedef struct packed {
        logic rts_enable;
        logic fan_on;
        logic recorder_reset;
    } ctrl_t;
    localparam ctrl_t CTRL_RESET = '{rts_enable: 1'b0, fan_on: 1'b0, recorder_reset: 1'b0};
    localparam logic [EV_WIDTH-1:0] MASK_RESET = 5'h00;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// >>> recorder_serial_link.sv
`timescale 1ns/100ps
module recorder_serial_link
    import recorder_serial_link_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // AXI4-Lite write address and data
    input wire logic [5:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [5:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Recorder serial link
    output logic TXD,
    input wire logic RXD,
    output logic RTS_N,
    input wire logic CTS_N,
    input wire logic RECORDER_READY_IRQ_N,
    output logic RECORDER_RESET_N,
    // Fan
    output logic FAN_ON,
    input wire logic FAN_STATUS,
    // Interrupt
    output logic IRQ
);

    // Pin synchronisers: rxd, cts, ready, fan
    logic [3:0] sync_meta;
    logic [3:0] sync_pins;
    logic rxd_s;
    logic cts_ok;
    logic ready_ok;
    logic fan_running;
    logic ready_prev;
    logic fan_prev;

    // Registers
    ctrl_t ctrl;
    logic [EV_WIDTH-1:0] irq_status;
    logic [EV_WIDTH-1:0] irq_mask;
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] rx_data;
    logic rx_valid;

    // Bus state
    logic [5:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    // Transmitter
    tx_state_t tx_state;
    logic [10:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;

    // Receiver
    rx_state_t rx_state;
    logic [10:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_meta <= 4'hf;
            sync_pins <= 4'hf;
        end else begin
            sync_meta <= {FAN_STATUS, RECORDER_READY_IRQ_N, CTS_N, RXD};
            sync_pins <= sync_meta;
        end
    end

    // Synchronised pin views
    assign rxd_s = sync_pins[0];
    assign cts_ok = ~sync_pins[1];
    assign ready_ok = ~sync_pins[2];
    assign fan_running = sync_pins[3];

    // Write decode: performed once address and data are both held
    logic do_write;
    logic wr_lane0;
    logic wr_tx;
    logic wr_ctrl;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic wr_hit;
    assign do_write = aw_held && w_held && !BVALID;
    assign wr_lane0 = do_write && w_strb[0];
    assign wr_tx = wr_lane0 && (aw_addr == OFS_TX_DATA);
    assign wr_ctrl = wr_lane0 && (aw_addr == OFS_CONTROL);
    assign wr_irq_status = wr_lane0 && (aw_addr == OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_lane0 && (aw_addr == OFS_IRQ_MASK);
    assign wr_hit = (aw_addr == OFS_TX_DATA) || (aw_addr == OFS_RX_DATA)
                 || (aw_addr == OFS_CONTROL) || (aw_addr == OFS_STATUS)
                 || (aw_addr == OFS_IRQ_STATUS) || (aw_addr == OFS_IRQ_MASK);

    // Read decode
    logic do_read;
    logic rd_rx;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [7:0] status_byte;
    assign do_read = ARVALID && ARREADY;
    assign rd_rx = do_read && (ARADDR == OFS_RX_DATA);
    assign status_byte = {2'h0, rx_valid, fan_running, ready_ok, cts_ok, tx_full,
                          tx_state != TX_IDLE};

    // Read data selection
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (ARADDR == OFS_TX_DATA) begin
            rd_word = {24'h00_0000, tx_hold};
        end else if (ARADDR == OFS_RX_DATA) begin
            rd_word = {23'h00_0000, rx_valid, rx_data};
        end else if (ARADDR == OFS_CONTROL) begin
            rd_word = {29'h0000_0000, ctrl};
        end else if (ARADDR == OFS_STATUS) begin
            rd_word = {24'h00_0000, status_byte}; // Fan status readable
        end else if (ARADDR == OFS_IRQ_STATUS) begin
            rd_word = {27'h000_0000, irq_status};
        end else if (ARADDR == OFS_IRQ_MASK) begin
            rd_word = {27'h000_0000, irq_mask};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Write channel handshakes and response
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_addr <= AWADDR;
                aw_held <= 1'b1;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_data <= WDATA;
                w_strb <= WSTRB;
                w_held <= 1'b1;
                WREADY <= 1'b0;
            end
            if (do_write) begin
                BVALID <= 1'b1;
                BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= RESP_OKAY;
        end else if (do_read) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_word;
            RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // Control and mask registers
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl <= CTRL_RESET;
            irq_mask <= MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= ctrl_t'(w_data[2:0]);
            end
            if (wr_irq_mask) begin
                irq_mask <= w_data[EV_WIDTH-1:0];
            end
        end
    end

    // Pin drivers straight from flops
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RECORDER_RESET_N <= 1'b1;
            FAN_ON <= 1'b0;
            RTS_N <= 1'b1;
            IRQ <= 1'b0;
        end else begin
            RECORDER_RESET_N <= ~ctrl.recorder_reset; // Low only while asserted
            FAN_ON <= ctrl.fan_on; // Fan switch
            RTS_N <= ~(ctrl.rts_enable && !rx_valid);
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // Event sources; the set wins over a write-one clear
    logic tx_start;
    logic tx_done;
    logic rx_byte;
    logic rx_err;
    logic [EV_WIDTH-1:0] events;
    assign events = {rx_err, fan_running ^ fan_prev, ready_ok && ready_prev, rx_byte, tx_done};

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            irq_status <= 5'h00;
            ready_prev <= 1'b0;
            fan_prev <= 1'b1;
        end else begin
            ready_prev <= ~ready_ok; // Ready falling edge interrupt
            fan_prev <= fan_running;
            irq_status <= (irq_status & ~(wr_irq_status ? w_data[EV_WIDTH-1:0] : 5'h00))
                        | events;
        end
    end

    // Holding register: a write while full is dropped
    // Start needs clear-to-send and ready both asserted
    assign tx_start = (tx_state == TX_IDLE) && tx_full && cts_ok && ready_ok;
    assign tx_done = (tx_state == TX_STOP) && (tx_cnt == 11'h000);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tx_hold <= 8'h00;
            tx_full <= 1'b0;
        end else if (wr_tx && !tx_full) begin
            tx_hold <= w_data[7:0];
            tx_full <= 1'b1;
        end else if (tx_start) begin
            tx_full <= 1'b0;
        end
    end

    // Transmitter: start, 8 data LSB first, one stop, no parity
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tx_state <= TX_IDLE;
            tx_cnt <= 11'h000;
            tx_bit <= 3'h0;
            tx_shift <= 8'h00;
            TXD <= 1'b1;
        end else begin
            tx_cnt <= (tx_cnt == 11'h000) ? 11'h000 : tx_cnt - 11'h001;
            case (tx_state)
                TX_IDLE: begin
                    TXD <= 1'b1;
                    if (tx_start) begin
                        tx_shift <= tx_hold;
                        tx_cnt <= BAUD_DIV - 11'h001; // Bit time at 38.4 kbaud
                        TXD <= 1'b0;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_cnt == 11'h000) begin
                        TXD <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit <= 3'h0;
                        tx_cnt <= BAUD_DIV - 11'h001;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_cnt == 11'h000) begin
                        tx_cnt <= BAUD_DIV - 11'h001;
                        if (tx_bit == LAST_DATA_BIT) begin
                            TXD <= 1'b1;
                            tx_state <= TX_STOP;
                        end else begin
                            TXD <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_bit <= tx_bit + 3'h1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_cnt == 11'h000) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Receiver: centre sampling, stop must be high
    assign rx_byte = (rx_state == RX_STOP) && (rx_cnt == 11'h000) && rxd_s;
    assign rx_err = (rx_state == RX_STOP) && (rx_cnt == 11'h000) && !rxd_s;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 11'h000;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
        end else begin
            rx_cnt <= (rx_cnt == 11'h000) ? 11'h000 : rx_cnt - 11'h001;
            case (rx_state)
                RX_IDLE: begin
                    if (!rxd_s) begin
                        rx_cnt <= HALF_BIT - 11'h001;
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt == 11'h000) begin
                        rx_cnt <= BAUD_DIV - 11'h001;
                        rx_bit <= 3'h0;
                        rx_state <= rxd_s ? RX_IDLE : RX_DATA; // Glitch rejected
                    end
                end
                RX_DATA: begin
                    if (rx_cnt == 11'h000) begin
                        rx_shift <= {rxd_s, rx_shift[7:1]};
                        rx_cnt <= BAUD_DIV - 11'h001;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == LAST_DATA_BIT) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt == 11'h000) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Received byte; a new byte wins over the clearing read
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else if (rx_byte) begin
            rx_data <= rx_shift;
            rx_valid <= 1'b1;
        end else if (rd_rx) begin
            rx_valid <= 1'b0;
        end
    end

endmodule

// >>> recorder_serial_link_props.sv
`timescale 1ns/100ps
module recorder_serial_link_props
    import recorder_serial_link_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // Register bus
    input wire logic AWREADY,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic [5:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    // Recorder link
    input wire logic TXD,
    input wire logic CTS_N,
    input wire logic RECORDER_READY_IRQ_N,
    input wire logic RECORDER_RESET_N,
    input wire logic IRQ
);
    localparam int BIT = 1042;
    logic txd_q;
    logic act;
    logic [13:0] pos;
    wire go = !CTS_N && !RECORDER_READY_IRQ_N;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // Cycles since the start edge of the character on the line
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            txd_q <= 1'b1;
            act <= 1'b0;
            pos <= 14'h0;
        end else begin
            txd_q <= TXD;
            if (!act && txd_q && !TXD) begin
                act <= 1'b1;
                pos <= 14'h1;
            end else if (act && pos == 14'h28b3) begin
                act <= 1'b0;
                pos <= 14'h0;
            end else if (act) begin
                pos <= pos + 14'h1;
            end
        end
    end
    a_start_gated: assert property (
        !act && $fell(TXD) |-> $past(go) && $past(go, 2)) else $error("start while not ready");
    a_bit_period: assert property (
        act && $changed(TXD) |-> pos % BIT == 0) else $error("line changed off bit edge");
    a_start_low: assert property (
        act && pos < 14'h412 |-> !TXD) else $error("start bit not low");
    a_stop_high: assert property (
        act && pos >= 14'h24a2 |-> TXD) else $error("stop bit not high");
    a_read_answer: assert property (
        ARVALID && ARREADY |=> RVALID) else $error("read not answered");
    a_unmapped_read: assert property (
        ARVALID && ARREADY && ARADDR > 6'h14 |=> RVALID && RRESP == RESP_SLVERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_write_refused: assert property (
        BVALID |-> !AWREADY && !WREADY) else $error("write taken during response");
    a_read_refused: assert property (
        RVALID |-> !ARREADY) else $error("read taken during response");
    c_char_sent: cover property (!act && $fell(TXD));
    c_recorder_reset: cover property ($fell(RECORDER_RESET_N));
    c_irq: cover property ($rose(IRQ));
endmodule
bind recorder_serial_link recorder_serial_link_props u_props (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .TXD(TXD), .CTS_N(CTS_N), .RECORDER_READY_IRQ_N(RECORDER_READY_IRQ_N),
    .RECORDER_RESET_N(RECORDER_RESET_N), .IRQ(IRQ));

// >>> recorder_model.sv
`timescale 1ns/100ps
module recorder_model (
    // Link from the host
    input wire logic clk,
    input wire logic txd,
    input wire logic rts_n,
    input wire logic fan_on,
    input wire logic [15:0] hold_cycles,
    // Link to the host
    output logic cts_n,
    output logic ready_n,
    output logic rxd,
    output logic fan_status
);
    logic [7:0] got [$];
    logic [3:0] fan_q = 4'h0;
    int frame_errs = 0;
    // Fan reports running a few cycles after it is switched
    always @(posedge clk) fan_q <= {fan_q[2:0], fan_on};
    assign fan_status = fan_q[3];
    // Take characters mid-bit, then stay busy while processing each one
    initial begin : rx_loop
        logic [7:0] b;
        cts_n = 1'b0;
        ready_n = 1'b0;
        rxd = 1'b1;
        forever begin
            @(posedge clk);
            if (txd === 1'b0) begin
                repeat (521) @(posedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (1042) @(posedge clk);
                    b[i] = txd;
                end
                repeat (1042) @(posedge clk);
                if (txd !== 1'b1) frame_errs++;
                got.push_back(b);
                cts_n <= 1'b1;
                ready_n <= 1'b1;
                repeat (hold_cycles) @(posedge clk);
                cts_n <= 1'b0;
                ready_n <= 1'b0;
            end
        end
    end
    // Send one character once the host allows it
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        int n;
        f = {stop, b, 1'b0};
        n = 0;
        while (rts_n !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (1042) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask
endmodule

// >>> recorder_serial_link_test.sv
`timescale 1ns/100ps
module recorder_serial_link_test
    import recorder_serial_link_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] awaddr = 6'h0;
    logic [5:0] araddr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic [15:0] hold = 16'h10;
    logic awready, wready, bvalid, arready, rvalid, txd, rts_n, cts_n, ready_n;
    logic reset_n, fan_on, fan_status, irq, rxd;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int failures = 0;
    int compares = 0;
    always #12.5 clk = ~clk;
    recorder_serial_link dut (.CLOCK(clk), .SYS_RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1),
        .TXD(txd), .RXD(rxd), .RTS_N(rts_n), .CTS_N(cts_n), .RECORDER_READY_IRQ_N(ready_n),
        .RECORDER_RESET_N(reset_n), .FAN_ON(fan_on), .FAN_STATUS(fan_status), .IRQ(irq));
    recorder_model mdl (.clk(clk), .txd(txd), .rts_n(rts_n), .fan_on(fan_on), .hold_cycles(hold),
        .cts_n(cts_n), .ready_n(ready_n), .rxd(rxd), .fan_status(fan_status));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Register write, both channels offered together
    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        chk(32'(bresp), 32'(RESP_OKAY));
    endtask
    // Register read with masked compare
    task automatic axr(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        chk(rdata & m, e);
        chk(32'(rresp), 32'(r));
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({29'h0, txd, reset_n, fan_on}, 32'h6);
        axr(OFS_CONTROL, 32'h7, 32'h0, RESP_OKAY);
        axw(OFS_IRQ_STATUS, 32'h1f);
        axw(OFS_CONTROL, 32'h3);
        repeat (8) @(posedge clk);
        chk({30'h0, reset_n, fan_on}, 32'h1);
        axr(OFS_STATUS, 32'h10, 32'h10, RESP_OKAY);
        axw(OFS_CONTROL, 32'h4);
        repeat (8) @(posedge clk);
        chk({29'h0, reset_n, fan_on, rts_n}, 32'h4);
        axr(OFS_STATUS, 32'h10, 32'h0, RESP_OKAY);
        axr(6'h18, 32'hffffffff, 32'h0, RESP_SLVERR);
        // Two characters back to back, recorder slow to finish each
        hold <= 16'hbb8;
        axw(OFS_IRQ_MASK, 32'h1);
        axw(OFS_TX_DATA, 32'ha5);
        axw(OFS_TX_DATA, 32'h3c);
        for (int n = 0; n < 40000 && !(mdl.got.size() == 2 && ready_n === 1'b0); n++) begin
            @(posedge clk);
        end
        chk(32'(mdl.got.size()), 32'h2);
        chk({16'h0, mdl.got[0], mdl.got[1]}, 32'ha53c);
        chk(32'(mdl.frame_errs), 32'h0);
        chk({31'h0, irq}, 32'h1);
        axw(OFS_IRQ_STATUS, 32'h1f);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        axr(OFS_STATUS, 32'hf, 32'hc, RESP_OKAY);
        // Characters from the recorder, one good and one with a bad stop bit
        mdl.send_byte(8'h96, 1'b1);
        repeat (4) @(posedge clk);
        axr(OFS_RX_DATA, 32'h1ff, 32'h196, RESP_OKAY);
        axr(OFS_RX_DATA, 32'h100, 32'h0, RESP_OKAY);
        mdl.send_byte(8'h55, 1'b0);
        repeat (4) @(posedge clk);
        axr(OFS_IRQ_STATUS, 32'h12, 32'h12, RESP_OKAY);
        summarize();
    end
    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
